// ===== core/halt_mode_power_controller.sv
/*
 Halt-mode power controller: decodes the halt opcode, chooses between
 active-halt, plain halt and self-wake sleep, gates clocks, times the
 256-cycle oscillator stabilisation and runs the self-wake unit.
 Assumes CPU, timers, watchdog and interrupt logic on aclk, and a wake
 RC clock arriving as a plain asynchronous input pin.
*/
`timescale 1ns/100ps
module halt_mode_power_controller #(
   parameter int FIXED_DIV = pwr_pkg::FIXED_DIVIDER
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic opcode_valid,
   input wire logic [7:0] opcode,
   input wire logic lite_timer_irq,
   input wire logic reload_timer_irq,
   input wire logic halt_exit_irq,
   input wire logic reset_request,
   input wire logic watchdog_active,
   input wire logic wake_rc_clk,
   input wire logic wake_irq_ack,
   input wire logic [1:0] wake_irq_priority,
   input wire logic [1:0] ccr_level_now,
   input wire logic ccr_pop,
   output logic cpu_stall,
   output logic clear_irq_mask,
   output logic fetch_reset_vector,
   output logic resume_irq,
   output logic main_osc_enable,
   output logic peripheral_clk_enable,
   output logic timer_clk_enable,
   output logic wake_osc_enable,
   output logic capture_from_wake_clk,
   output logic capture_wake_clk,
   output logic wake_irq,
   output logic watchdog_reset_req,
   output logic ccr_level_load,
   output logic [1:0] ccr_level
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pwr_pkg::pwr_state_t state_q, state_d;
   logic [8:0] stab_cnt_q;
   logic stab_for_reset_q;
   logic [4:0] cfg_q;
   logic wake_en_q, measure_q, wake_flag_q;
   logic [7:0] presc_q;
   logic [7:0] fix_cnt_q, presc_cnt_q;
   logic [2:0] rc_sync_q;
   logic [1:0] saved_level_q;
   logic aw_held_q, w_held_q;
   logic [3:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic clear_mask_q, fetch_q, resume_q, wdg_req_q, level_load_q, capture_q;
   logic [1:0] level_q;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire halt_exec = opcode_valid && opcode == pwr_pkg::HALT_OPCODE;
   wire ck_qualifies = {cfg_q[pwr_pkg::COUNTER_CLOCK_SELECT_HI_BIT],
      cfg_q[pwr_pkg::COUNTER_CLOCK_SELECT_LO_BIT]} == pwr_pkg::QUALIFYING_CLOCK_SELECT;
   wire active_sel = cfg_q[pwr_pkg::TIMEBASE_IRQ_ENABLE_BIT] ||
      (cfg_q[pwr_pkg::OVERFLOW_IRQ_ENABLE_BIT] && ck_qualifies);
   wire in_run = state_q == pwr_pkg::ST_RUN;
   wire halt_go = in_run && halt_exec;
   wire timer_irq = lite_timer_irq || reload_timer_irq;
   wire halt_irq = halt_exit_irq || timer_irq;
   wire rc_rise = rc_sync_q[1] && !rc_sync_q[2];
   wire in_sleep = state_q == pwr_pkg::ST_SELF_WAKE_SLEEP;
   wire fix_tick = in_sleep && rc_rise && fix_cnt_q == 8'(FIXED_DIV - 1);
   wire wake_expire = fix_tick && presc_cnt_q == presc_q - 8'h01;
   wire stab_done = state_q == pwr_pkg::ST_STABILISE && stab_cnt_q == pwr_pkg::STAB_LAST;

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         pwr_pkg::ST_RUN: begin
            if (halt_exec) begin
               if (active_sel) state_d = pwr_pkg::ST_ACTIVE_HALT;
               else if (wake_en_q) state_d = pwr_pkg::ST_SELF_WAKE_SLEEP;
               else state_d = pwr_pkg::ST_HALT;
            end
         end
         pwr_pkg::ST_ACTIVE_HALT: begin
            if (reset_request) state_d = pwr_pkg::ST_STABILISE;
            else if (timer_irq) state_d = pwr_pkg::ST_RUN;
         end
         pwr_pkg::ST_HALT: begin
            if (reset_request || halt_irq) state_d = pwr_pkg::ST_STABILISE;
         end
         pwr_pkg::ST_SELF_WAKE_SLEEP: begin
            if (reset_request || halt_irq || wake_expire) begin
               state_d = pwr_pkg::ST_STABILISE;
            end
         end
         pwr_pkg::ST_STABILISE: begin
            if (stab_done) state_d = pwr_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= pwr_pkg::ST_RUN;
         stab_cnt_q <= 9'h000;
         stab_for_reset_q <= 1'b0;
      end else begin
         state_q <= state_d;
         stab_cnt_q <= (state_q == pwr_pkg::ST_STABILISE) ? stab_cnt_q + 9'h001 : 9'h000;
         if (state_q != pwr_pkg::ST_STABILISE) stab_for_reset_q <= reset_request;
      end
   end

   // ----------------------------------------------------------------
   // CPU side strobes
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clear_mask_q <= 1'b0;
         fetch_q <= 1'b0;
         resume_q <= 1'b0;
         wdg_req_q <= 1'b0;
      end else begin
         clear_mask_q <= halt_go;
         // Option set: halt with watchdog running asks for a reset in every halt mode
         wdg_req_q <= halt_go && watchdog_active &&
            cfg_q[pwr_pkg::WATCHDOG_STOP_OPTION_BIT];
         fetch_q <= stab_done && stab_for_reset_q;
         resume_q <= (stab_done && !stab_for_reset_q) ||
            (state_q == pwr_pkg::ST_ACTIVE_HALT && !reset_request && timer_irq);
      end
   end

   // Priority bits follow the pushed condition code register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         saved_level_q <= 2'h0;
         level_q <= 2'h0;
         level_load_q <= 1'b0;
      end else begin
         level_load_q <= wake_irq_ack || ccr_pop;
         if (wake_irq_ack) begin
            saved_level_q <= ccr_level_now;
            level_q <= wake_irq_priority;
         end else if (ccr_pop) begin
            level_q <= saved_level_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Self-wake unit
   // ----------------------------------------------------------------
   // Wake clock is far slower than aclk, so sampling it as a pin is enough
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rc_sync_q <= 3'h0;
         fix_cnt_q <= 8'h00;
         presc_cnt_q <= 8'h00;
         capture_q <= 1'b0;
      end else begin
         rc_sync_q <= {rc_sync_q[1:0], wake_rc_clk};
         capture_q <= rc_sync_q[1] && measure_q && in_run;
         if (!in_sleep) begin
            fix_cnt_q <= 8'h00;
            presc_cnt_q <= 8'h00;
         end else if (rc_rise) begin
            fix_cnt_q <= fix_tick ? 8'h00 : fix_cnt_q + 8'h01;
            if (fix_tick) presc_cnt_q <= wake_expire ? 8'h00 : presc_cnt_q + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock gating
   // ----------------------------------------------------------------
   assign cpu_stall = !in_run;
   assign main_osc_enable = in_run || state_q == pwr_pkg::ST_ACTIVE_HALT ||
      state_q == pwr_pkg::ST_STABILISE;
   assign peripheral_clk_enable = in_run;
   assign timer_clk_enable = in_run || state_q == pwr_pkg::ST_ACTIVE_HALT;
   assign wake_osc_enable = in_sleep || measure_q;
   assign capture_from_wake_clk = measure_q && in_run;
   assign capture_wake_clk = capture_q;
   assign clear_irq_mask = clear_mask_q;
   assign fetch_reset_vector = fetch_q;
   assign resume_irq = resume_q;
   assign watchdog_reset_req = wdg_req_q;
   assign wake_irq = wake_flag_q;
   assign ccr_level_load = level_load_q;
   assign ccr_level = level_q;

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   wire wr_csr = wr_fire && aw_addr_q == pwr_pkg::WAKE_CTRL_STATUS_REG_OFS && w_strb_q[0];
   wire wr_presc = wr_fire && aw_addr_q == pwr_pkg::WAKE_PRESCALER_REG_OFS && w_strb_q[0];
   wire wr_cfg = wr_fire && aw_addr_q == pwr_pkg::MODE_CFG_OFS && w_strb_q[0];
   wire wr_hit = aw_addr_q == pwr_pkg::WAKE_CTRL_STATUS_REG_OFS ||
      aw_addr_q == pwr_pkg::WAKE_PRESCALER_REG_OFS || aw_addr_q == pwr_pkg::MODE_CFG_OFS;
   wire rd_fire = s_axi_arvalid && s_axi_arready;
   wire rd_csr = rd_fire && s_axi_araddr == pwr_pkg::WAKE_CTRL_STATUS_REG_OFS;
   wire [31:0] csr_word = {29'h0, wake_flag_q, measure_q, wake_en_q};
   logic [31:0] rd_word;
   logic rd_hit;

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         pwr_pkg::WAKE_CTRL_STATUS_REG_OFS: rd_word = csr_word;
         pwr_pkg::WAKE_PRESCALER_REG_OFS: rd_word = {24'h0, presc_q};
         pwr_pkg::MODE_CFG_OFS: rd_word = {27'h0, cfg_q};
         pwr_pkg::MODE_STATUS_OFS: rd_word = {28'h0, cpu_stall, state_q};
         default: rd_hit = 1'b0;
      endcase
   end

   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready = !w_held_q;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 4'h0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pwr_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? pwr_pkg::RESP_OKAY : pwr_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= pwr_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? pwr_pkg::RESP_OKAY : pwr_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_en_q <= 1'b0;
         measure_q <= 1'b0;
         wake_flag_q <= 1'b0;
         presc_q <= pwr_pkg::WAKE_PRESCALER_RESET;
         cfg_q <= pwr_pkg::MODE_CFG_RESET;
      end else begin
         if (wr_csr) begin
            wake_en_q <= w_data_q[pwr_pkg::WAKE_TIMER_ENABLE_BIT];
            measure_q <= w_data_q[pwr_pkg::WAKE_CLOCK_MEASURE_BIT];
         end
         // Expiry beats a same-cycle read, so no wakeup is lost
         if (wake_expire) wake_flag_q <= 1'b1;
         else if (rd_csr) wake_flag_q <= 1'b0;
         if (wr_presc && w_data_q[7:0] != pwr_pkg::WAKE_PRESCALER_IGNORED) begin
            presc_q <= w_data_q[7:0];
         end
         if (wr_cfg) cfg_q <= w_data_q[4:0];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [9:0] stall_cnt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) stall_cnt_q <= 10'h000;
      else stall_cnt_q <= (state_q == pwr_pkg::ST_STABILISE) ? stall_cnt_q + 10'h001 : 10'h000;
   end

   a_active_choice: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_go && active_sel |=> state_q == pwr_pkg::ST_ACTIVE_HALT)
      else $error("active-halt not chosen");
   a_active_exit: assert property (@(posedge aclk) disable iff (!aresetn)
      state_q == pwr_pkg::ST_ACTIVE_HALT && !timer_irq && !reset_request
      |=> state_q == pwr_pkg::ST_ACTIVE_HALT)
      else $error("active-halt left without cause");
   a_stab_length: assert property (@(posedge aclk) disable iff (!aresetn)
      state_q == pwr_pkg::ST_STABILISE |-> stall_cnt_q < pwr_pkg::STAB_CYCLES)
      else $error("stabilisation too long");
   a_reset_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(state_q == pwr_pkg::ST_STABILISE) && stab_for_reset_q
      |-> ##256 fetch_reset_vector)
      else $error("reset vector fetch not after 256 cycles");
   a_irq_resume: assert property (@(posedge aclk) disable iff (!aresetn)
      state_q == pwr_pkg::ST_ACTIVE_HALT && timer_irq && !reset_request
      |=> in_run && resume_irq)
      else $error("timer wake not immediate");
   a_mask_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      halt_go |=> clear_irq_mask && cpu_stall)
      else $error("mask not cleared on halt");
   a_halt_clocks: assert property (@(posedge aclk) disable iff (!aresetn)
      state_q == pwr_pkg::ST_HALT |-> !main_osc_enable && !peripheral_clk_enable)
      else $error("clocks running in halt");
   a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
      wake_expire |=> wake_flag_q && state_q == pwr_pkg::ST_STABILISE)
      else $error("wake expiry lost");
   a_flag_read: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_csr && !wake_expire |=> !wake_irq)
      else $error("flag not cleared by read");
   a_presc_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_presc && w_data_q[7:0] == 8'h00 |=> $stable(presc_q))
      else $error("zero prescaler accepted");

   c_active_cycle: cover property (@(posedge aclk) disable iff (!aresetn)
      state_q == pwr_pkg::ST_ACTIVE_HALT ##1 resume_irq);
   c_self_wake: cover property (@(posedge aclk) disable iff (!aresetn) wake_expire);
   c_halt_reset: cover property (@(posedge aclk) disable iff (!aresetn)
      state_q == pwr_pkg::ST_HALT ##1 reset_request ##[1:300] fetch_reset_vector);
endmodule

// ===== core/pwr_pkg.sv
/*
 Constants for the halt-mode power controller: register map, field
 positions, reset values and timing counts.
 Assumes a 20 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
package pwr_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] WAKE_CTRL_STATUS_REG_OFS = 4'h0;
   localparam logic [3:0] WAKE_PRESCALER_REG_OFS = 4'h4;
   localparam logic [3:0] MODE_CFG_OFS = 4'h8;
   localparam logic [3:0] MODE_STATUS_OFS = 4'hC;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int WAKE_TIMER_ENABLE_BIT = 0;
   localparam int WAKE_CLOCK_MEASURE_BIT = 1;
   localparam int WAKE_TIMER_FLAG_BIT = 2;
   localparam int TIMEBASE_IRQ_ENABLE_BIT = 0;
   localparam int OVERFLOW_IRQ_ENABLE_BIT = 1;
   localparam int COUNTER_CLOCK_SELECT_LO_BIT = 2;
   localparam int COUNTER_CLOCK_SELECT_HI_BIT = 3;
   localparam int WATCHDOG_STOP_OPTION_BIT = 4;
   // ----------------------------------------------------------------
   // Reset values and codes
   // ----------------------------------------------------------------
   localparam logic [7:0] WAKE_PRESCALER_RESET = 8'hFF;
   localparam logic [7:0] WAKE_PRESCALER_IGNORED = 8'h00;
   localparam logic [4:0] MODE_CFG_RESET = 5'h00;
   localparam logic [1:0] QUALIFYING_CLOCK_SELECT = 2'h1;
   localparam logic [7:0] HALT_OPCODE = 8'h8E;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int STAB_CYCLES = 256;
   localparam logic [8:0] STAB_LAST = 9'(STAB_CYCLES - 1);
   localparam int FIXED_DIVIDER = 16;
   // ----------------------------------------------------------------
   // Power states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RUN, ST_ACTIVE_HALT, ST_HALT, ST_SELF_WAKE_SLEEP, ST_STABILISE
   } pwr_state_t;
endpackage

// ===== testbench/cpu_side_model.sv
/*
 Behavioural CPU-side partner: makes the wake RC clock and services the wake interrupt.
 Assumes aclk-synchronous outputs from the power controller.
*/
`timescale 1ns/100ps
module cpu_side_model (
   input wire logic aclk,
   input wire logic wake_osc_enable,
   input wire logic resume_irq,
   input wire logic wake_irq,
   output logic wake_rc_clk,
   output logic wake_irq_ack = 1'b0,
   output logic [1:0] wake_irq_priority,
   output logic [1:0] ccr_level_now,
   output logic ccr_pop = 1'b0
);
   // ----------------------------------------
   // Wake clock and interrupt service
   // ----------------------------------------
   // Software has moved the CPU clock to the slow RC before any halt
   logic [2:0] div_q = 3'h0;
   // Clock at aclk/8, held low while the oscillator is off, well under aclk/4
   assign wake_rc_clk = div_q[2];
   assign wake_irq_priority = 2'h2;
   assign ccr_level_now = 2'h1;
   always_ff @(posedge aclk) begin
      div_q <= wake_osc_enable ? div_q + 3'h1 : 3'h0;
      wake_irq_ack <= resume_irq & wake_irq;
      ccr_pop <= wake_irq_ack;
   end
endmodule

// ===== testbench/halt_mode_power_controller_tb.sv
/*
 Self-checking bench for the halt-mode power controller.
 Assumes the design package and the CPU-side partner model are compiled first.
*/
`timescale 1ns/100ps
module halt_mode_power_controller_tb;
   logic aclk, aresetn, awvalid, wvalid, bvalid, arvalid, rvalid, awready, wready, arready;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, prio, lnow, lvl;
   logic [7:0] opc;
   logic opv, lt, rt, hx, rq, wd, wclk, ack, pop, stall, cim, frv, rsm, mosc, pclk, tclk;
   logic wosc, capf, capc, wirq, wdr, lload, bready, rready;
   int miscompares, total_checks;
   halt_mode_power_controller #(.FIXED_DIV(2)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .opcode_valid(opv), .opcode(opc), .lite_timer_irq(lt), .reload_timer_irq(rt),
      .halt_exit_irq(hx), .reset_request(rq), .watchdog_active(wd), .wake_rc_clk(wclk),
      .wake_irq_ack(ack), .wake_irq_priority(prio), .ccr_level_now(lnow), .ccr_pop(pop),
      .cpu_stall(stall), .clear_irq_mask(cim), .fetch_reset_vector(frv), .resume_irq(rsm),
      .main_osc_enable(mosc), .peripheral_clk_enable(pclk), .timer_clk_enable(tclk),
      .wake_osc_enable(wosc), .capture_from_wake_clk(capf), .capture_wake_clk(capc),
      .wake_irq(wirq), .watchdog_reset_req(wdr), .ccr_level_load(lload), .ccr_level(lvl));
   cpu_side_model partner (.aclk(aclk), .wake_osc_enable(wosc), .resume_irq(rsm),
      .wake_irq(wirq), .wake_rc_clk(wclk), .wake_irq_ack(ack), .wake_irq_priority(prio),
      .ccr_level_now(lnow), .ccr_pop(pop));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic give_up();
      miscompares++;
      tally_and_finish();
   endtask
   // Every driver starts one edge on, so no signal is assigned twice in a time step
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 20) give_up();
      check("bresp", bresp, exp);
   endtask
   task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] exp);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 20) give_up();
      check(nm, rdata, exp);
      check("rresp", rresp, pwr_pkg::RESP_OKAY);
   endtask
   task automatic halt_op(input logic [7:0] code, input logic st, input logic wexp);
      @(posedge aclk);
      opc <= code;
      opv <= 1'b1;
      @(posedge aclk);
      opv <= 1'b0;
      #1;
      check("stall", stall, st);
      check("mask clear", cim, st);
      check("watchdog req", wdr, wexp);
   endtask
   // Source order is lite timer, reload timer, other halt interrupt, reset request
   task automatic exit_run(input logic [3:0] src, input int exp_n, input logic v, input logic i);
      int n;
      @(posedge aclk);
      {lt, rt, hx, rq} <= src;
      for (n = 1; n < 400; n++) begin
         @(posedge aclk);
         {lt, rt, hx, rq} <= 4'h0;
         #1;
         if (stall === 1'b0) break;
      end
      if (n == 400) give_up();
      if (exp_n > 0) check("exit cycles", n, exp_n);
      if (exp_n == 0) check("wake delay", n inside {[270:310]}, 1);
      check("reset vector", frv, v);
      check("irq resume", rsm, i);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic reset_and_bus();
      int n;
      rdc("prescaler", 4'h4, 32'hFF);
      rdc("status", 4'hC, 32'h0);
      wr(4'hC, 32'h1, pwr_pkg::RESP_SLVERR);
      halt_op(8'h8F, 1'b0, 1'b0);
      wr(4'h0, 32'h2, pwr_pkg::RESP_OKAY);
      #1;
      check("capture route", capf, 1'b1);
      for (n = 0; n < 20 && capc !== 1'b1; n++) begin
         @(posedge aclk);
         #1;
      end
      if (n == 20) give_up();
      check("capture clock", capc, 1'b1);
      wr(4'h0, 32'h0, pwr_pkg::RESP_OKAY);
   endtask
   task automatic mode_select();
      logic [4:0] cfg [4] = '{5'h01, 5'h06, 5'h0A, 5'h00};
      for (int k = 0; k < 4; k++) begin
         wr(4'h8, 32'(cfg[k]), pwr_pkg::RESP_OKAY);
         halt_op(pwr_pkg::HALT_OPCODE, 1'b1, 1'b0);
         rdc("status", 4'hC, (k < 2) ? 32'h9 : 32'hA);
         check("timer clk", tclk, k < 2);
         check("main osc", mosc, k < 2);
         check("periph clk", pclk, 1'b0);
         exit_run(4'h1, 257, 1'b1, 1'b0);
      end
   endtask
   task automatic irq_exits();
      wr(4'h8, 32'h1, pwr_pkg::RESP_OKAY);
      halt_op(pwr_pkg::HALT_OPCODE, 1'b1, 1'b0);
      @(posedge aclk);
      hx <= 1'b1;
      repeat (3) @(posedge aclk);
      check("still halted", stall, 1'b1);
      exit_run(4'h8, 1, 1'b0, 1'b1);
      wr(4'h8, 32'h6, pwr_pkg::RESP_OKAY);
      halt_op(pwr_pkg::HALT_OPCODE, 1'b1, 1'b0);
      exit_run(4'h4, 1, 1'b0, 1'b1);
      wr(4'h8, 32'h0, pwr_pkg::RESP_OKAY);
      halt_op(pwr_pkg::HALT_OPCODE, 1'b1, 1'b0);
      exit_run(4'h2, 257, 1'b0, 1'b1);
   endtask
   task automatic watchdog();
      @(posedge aclk);
      wd <= 1'b1;
      wr(4'h8, 32'h10, pwr_pkg::RESP_OKAY);
      halt_op(pwr_pkg::HALT_OPCODE, 1'b1, 1'b1);
      exit_run(4'h1, 257, 1'b1, 1'b0);
      wr(4'h8, 32'h1, pwr_pkg::RESP_OKAY);
      halt_op(pwr_pkg::HALT_OPCODE, 1'b1, 1'b0);
      exit_run(4'h8, 1, 1'b0, 1'b1);
   endtask
   task automatic self_wake();
      wr(4'h4, 32'h0, pwr_pkg::RESP_OKAY);
      rdc("prescaler", 4'h4, 32'hFF);
      wr(4'h4, 32'h2, pwr_pkg::RESP_OKAY);
      rdc("prescaler", 4'h4, 32'h2);
      wr(4'h0, 32'h5, pwr_pkg::RESP_OKAY);
      rdc("wake ctrl", 4'h0, 32'h1);
      wr(4'h8, 32'h0, pwr_pkg::RESP_OKAY);
      halt_op(pwr_pkg::HALT_OPCODE, 1'b1, 1'b0);
      check("wake osc", wosc, 1'b1);
      check("main osc", mosc, 1'b0);
      exit_run(4'h0, 0, 1'b0, 1'b1);
      repeat (2) @(posedge aclk);
      #1;
      check("level pushed", lvl, 2'h2);
      check("level load", lload, 1'b1);
      @(posedge aclk);
      #1;
      check("level popped", lvl, 2'h1);
      check("wake irq", wirq, 1'b1);
      rdc("wake ctrl", 4'h0, 32'h5);
      rdc("wake ctrl", 4'h0, 32'h1);
      check("wake irq", wirq, 1'b0);
   endtask
   task automatic mid_reset();
      halt_op(pwr_pkg::HALT_OPCODE, 1'b1, 1'b0);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      check("stall", stall, 1'b0);
      check("main osc", mosc, 1'b1);
      rdc("status", 4'hC, 32'h0);
   endtask
   // ----------------------------------------
   // Clock and main sequence
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, arvalid, opv, lt, rt, hx, rq, wd} = '0;
      {awaddr, araddr, wdata, opc} = '0;
      {bready, rready, wstrb} = 6'h3F;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      reset_and_bus();
      mode_select();
      irq_exits();
      watchdog();
      self_wake();
      mid_reset();
      tally_and_finish();
   end
endmodule
